// file: hdl/sfbc_pkg.sv
package sfbc_pkg;
    // register offsets (byte addresses, word aligned)
    localparam logic [7:0] REG_CMD       = 8'h00;
    localparam logic [7:0] REG_TEST_ANG  = 8'h04;
    localparam logic [7:0] REG_ANG_ERR   = 8'h08;
    localparam logic [7:0] REG_MGR_ERR   = 8'h0C;
    localparam logic [7:0] REG_ABS_CFG   = 8'h10;
    localparam logic [7:0] REG_HOME_OFS  = 8'h14;
    localparam logic [7:0] REG_POS_OUT   = 8'h18;
    localparam logic [7:0] REG_PHYS_POS  = 8'h1C;
    localparam logic [7:0] REG_AUX_CFG   = 8'h20;
    localparam logic [7:0] REG_SIM_RATE  = 8'h24;
    localparam logic [7:0] REG_SIM_POS   = 8'h28;
    localparam logic [7:0] REG_SEL_POS   = 8'h2C;
    localparam logic [7:0] REG_SEL_RATE  = 8'h30;
    localparam logic [7:0] REG_BRK_CFG   = 8'h34;
    localparam logic [7:0] REG_REL_DLY   = 8'h38;
    localparam logic [7:0] REG_ENG_DLY   = 8'h3C;
    localparam logic [7:0] REG_BRK_STAT  = 8'h40;
    localparam logic [7:0] REG_PHYS_VEL  = 8'h44;
    // manager command and error codes
    localparam logic [15:0] CMD_PHASE_TEST = 16'h14BE; // 5310
    localparam logic [15:0] CMD_PHASE_SAVE = 16'h14C8; // 5320
    localparam logic [15:0] CMD_HOME       = 16'h0001;
    localparam logic [15:0] ERR_PHASING    = 16'h14B5; // 5301
    localparam logic [15:0] ERR_NONE       = 16'h0000;
    // phasing limit on absolute angle error, in angle counts
    localparam logic [15:0] PHASE_ERR_LIMIT = 16'h0200;
    // sensor range; single and multiturn, 24-bit counts
    localparam logic [31:0] SENSOR_MAX      = 32'h00FF_FFFF;
    // reset values
    localparam logic [31:0] REL_DLY_RST     = 32'h0000_03E8;
    localparam logic [31:0] ENG_DLY_RST     = 32'h0000_03E8;
    // velocity sample window in cycles
    localparam int          VEL_WIN_US      = 1000;
    localparam int          CLK_MHZ         = 10;
    localparam logic [15:0] VEL_WIN_CYC     = 16'(VEL_WIN_US * CLK_MHZ);

    typedef enum logic [3:0] {
        SFBC_OFF     = 4'b0001,
        SFBC_RELEASE = 4'b0010,
        SFBC_RUN     = 4'b0100,
        SFBC_ENGAGE  = 4'b1000
    } sfbc_brk_t;

    typedef struct packed {
        logic       phase_a;
        logic       phase_b;
        logic       index;
    } sfbc_quad_t;
endpackage

// file: hdl/sfbc_top.sv
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
// Contract
// RULE_01: controller writes the test angle before issuing command 5310.
// RULE_02: after a phasing test, the angle error is readable.
// RULE_03: angle error above fixed limit raises manager error 5301.
// RULE_04: command 5320 stores the phasing result persistently.
// RULE_05: controller ends phasing test through the normal disable procedure.
// RULE_06: multiturn sensor defaults absolute mode to 1, position absolute.
// RULE_07: singleturn sensor defaults absolute mode 0, incremental until set.
// RULE_08: in absolute mode homing offset applies and is retained.
// RULE_09: controller re-homes after count or direction change, incremental.
// RULE_10: direction reversal mirrors position between zero and sensor maximum.
// RULE_11: tracking beyond range; power-down out of range voids homing.
// RULE_12: only an incremental quadrature encoder is the physical aux source.
// RULE_13: simulated aux encoder advances at a set rate under run/stop.
// RULE_14: external encoder drives A on I/O 0, B on I/O 1, index optional.
// RULE_15: direction 0 counts up when phase A leads phase B.
// RULE_16: direction 1 counts down; selector picks physical or simulated.
// RULE_17: brake follows every motor enable and disable automatically.
// RULE_18: on enable release brake, reject motion until release delay ends.
// RULE_19: on disable engage brake, hold current until engage delay ends.
// RULE_20: manual brake command honoured only while the motor is disabled.
module sfbc_top
    import sfbc_pkg::*;
(
    input  wire logic        mclk,          // 10 MHz drive clock
    input  wire logic        nrst,          // async reset, active low
    input  wire logic [7:0]  addr,          // register byte address
    input  wire logic [31:0] wdata,         // register write data
    input  wire logic        wr,            // write strobe
    input  wire logic        rd,            // read strobe
    output logic      [31:0] rdata,         // read data, cycle after rd
    input  wire logic        multiturn,     // sensor is multiturn absolute
    input  wire logic [31:0] sensor_pos,    // raw motor sensor position
    input  wire logic [15:0] meas_angle,    // measured electrical angle
    input  wire logic        phase_done,    // pulse: phasing measure finished
    output logic             phase_start,   // pulse: start phasing measure
    output logic             nvm_store,     // pulse: persist phasing/offset
    input  wire sfbc_quad_t  quad_in,       // aux encoder on I/O 0..2
    input  wire logic        motor_en_req,  // enable request from profile
    output logic             brake_release, // high: brake coil released
    output logic             current_on,    // high: motor current applied
    output logic             motion_ok      // high: motion commands accepted
);
    logic rst_s1_q, rst_s2_q;
    logic rst_n;

    // reset release through two flops; assertion stays asynchronous
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    function automatic logic [15:0] abs16(input logic [15:0] v);
        return v[15] ? 16'(-v) : v;
    endfunction

    logic [15:0] test_ang_q, ang_err_q, mgr_err_q;
    logic        abs_mode_q, reverse_q, home_valid_q, strap_done_q;
    logic [31:0] home_ofs_q, pos_out_q;
    logic        phase_busy_q;
    logic        cmd_wr;

    assign cmd_wr = wr && addr == REG_CMD;

    // phasing test: start, capture error, raise manager error
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            test_ang_q   <= 16'h0000;
            ang_err_q    <= 16'h0000;
            mgr_err_q    <= ERR_NONE;
            phase_busy_q <= 1'b0;
            phase_start  <= 1'b0;
            nvm_store    <= 1'b0;
        end else begin
            phase_start <= 1'b0;
            nvm_store   <= 1'b0;
            if (wr && addr == REG_TEST_ANG)
                test_ang_q <= wdata[15:0];
            if (wr && addr == REG_MGR_ERR)
                mgr_err_q <= ERR_NONE;        // software clear
            if (cmd_wr && wdata[15:0] == CMD_PHASE_TEST) begin
                phase_busy_q <= 1'b1;
                phase_start  <= 1'b1;
            end
            if (cmd_wr && wdata[15:0] == CMD_PHASE_SAVE)
                nvm_store <= 1'b1;            // RULE_04
            if (cmd_wr && wdata[15:0] == CMD_HOME && abs_mode_q)
                nvm_store <= 1'b1;            // RULE_08
            if (phase_busy_q && phase_done) begin
                phase_busy_q <= 1'b0;
                ang_err_q    <= 16'(meas_angle - test_ang_q); // RULE_02
                // set wins over a clear in the same cycle
                if (abs16(16'(meas_angle - test_ang_q)) > PHASE_ERR_LIMIT)
                    mgr_err_q <= ERR_PHASING; // RULE_03
            end
        end
    end

    // absolute mode default is caught once after reset release
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            abs_mode_q   <= 1'b0;
            strap_done_q <= 1'b0;
            reverse_q    <= 1'b0;
        end else begin
            strap_done_q <= 1'b1;
            if (!strap_done_q)
                abs_mode_q <= multiturn;      // RULE_06 RULE_07
            else if (wr && addr == REG_ABS_CFG)
                abs_mode_q <= wdata[0];       // RULE_07
            if (wr && addr == REG_ABS_CFG)
                reverse_q <= wdata[1];
        end
    end

    logic [31:0] shifted;
    // homing offset and reversal; wraps are tracked by 32-bit arithmetic
    assign shifted = sensor_pos + home_ofs_q;  // RULE_11

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            home_ofs_q   <= 32'h0000_0000;
            home_valid_q <= 1'b0;
            pos_out_q    <= 32'h0000_0000;
        end else begin
            if (cmd_wr && wdata[15:0] == CMD_HOME) begin
                home_ofs_q   <= 32'(-sensor_pos); // RULE_08
                home_valid_q <= 1'b1;
            end else if (wr && addr == REG_HOME_OFS) begin
                home_ofs_q   <= wdata;        // restored from nvm
                home_valid_q <= 1'b1;
            end else if (!abs_mode_q || sensor_pos > SENSOR_MAX) begin
                home_valid_q <= home_valid_q && !(!strap_done_q);
            end
            // after reset, sensor beyond range voids the stored homing
            if (!strap_done_q && sensor_pos > SENSOR_MAX)
                home_valid_q <= 1'b0;         // RULE_11
            if (reverse_q)
                pos_out_q <= SENSOR_MAX - shifted; // RULE_10
            else
                pos_out_q <= shifted;
        end
    end

    logic [1:0]  quad_q;
    logic [31:0] phys_pos_q, sim_pos_q, sim_rate_q;
    logic [31:0] phys_vel_q, vel_base_q, sel_pos_q, sel_rate_q;
    logic [15:0] vel_cnt_q;
    logic        phys_dir_q, sim_run_q, sel_sim_q;

    // quadrature decode; only a quadrature encoder is accepted
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            quad_q     <= 2'h0;
            phys_pos_q <= 32'h0000_0000;
        end else begin
            quad_q <= {quad_in.phase_a, quad_in.phase_b}; // RULE_12 RULE_14
            // a leads b: step when state moves 00-10-11-01
            if (quad_q[1] ^ quad_q[0]
                ^ quad_in.phase_a ^ quad_in.phase_b) begin
                if ((quad_in.phase_a ^ quad_q[0]) ^ phys_dir_q)
                    phys_pos_q <= phys_pos_q + 32'h1; // RULE_15
                else
                    phys_pos_q <= phys_pos_q - 32'h1; // RULE_16
            end
        end
    end

    // physical velocity: counts per sample window
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            vel_cnt_q  <= 16'h0000;
            vel_base_q <= 32'h0000_0000;
            phys_vel_q <= 32'h0000_0000;
        end else if (vel_cnt_q == VEL_WIN_CYC - 16'h1) begin
            vel_cnt_q  <= 16'h0000;
            vel_base_q <= phys_pos_q;
            phys_vel_q <= phys_pos_q - vel_base_q;
        end else begin
            vel_cnt_q <= vel_cnt_q + 16'h1;
        end
    end

    // aux config, simulated encoder and source selection
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phys_dir_q <= 1'b0;
            sim_run_q  <= 1'b0;
            sel_sim_q  <= 1'b0;
            sim_rate_q <= 32'h0000_0000;
            sim_pos_q  <= 32'h0000_0000;
            sel_pos_q  <= 32'h0000_0000;
            sel_rate_q <= 32'h0000_0000;
        end else begin
            if (wr && addr == REG_AUX_CFG) begin
                phys_dir_q <= wdata[0];
                sim_run_q  <= wdata[1];
                sel_sim_q  <= wdata[2];
            end
            if (wr && addr == REG_SIM_RATE)
                sim_rate_q <= wdata;
            if (wr && addr == REG_SIM_POS)
                sim_pos_q <= wdata;
            else if (sim_run_q)
                sim_pos_q <= sim_pos_q + sim_rate_q; // RULE_13
            sel_pos_q  <= sel_sim_q ? sim_pos_q  : phys_pos_q; // RULE_16
            sel_rate_q <= sel_sim_q ? sim_rate_q : phys_vel_q;
        end
    end

    sfbc_brk_t   brk_q;
    logic [31:0] rel_dly_q, eng_dly_q, brk_cnt_q;
    logic        manual_q;

    // brake sequencing tied to enable and disable
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            brk_q     <= SFBC_OFF;
            brk_cnt_q <= 32'h0000_0000;
        end else begin
            unique case (brk_q)
                SFBC_OFF: if (motor_en_req) begin
                    brk_q     <= SFBC_RELEASE; // RULE_17
                    brk_cnt_q <= rel_dly_q;
                end
                SFBC_RELEASE: if (!motor_en_req) begin
                    brk_q     <= SFBC_ENGAGE;
                    brk_cnt_q <= eng_dly_q;
                end else if (brk_cnt_q <= 32'h1) begin
                    brk_q <= SFBC_RUN;         // RULE_18
                end else begin
                    brk_cnt_q <= brk_cnt_q - 32'h1;
                end
                SFBC_RUN: if (!motor_en_req) begin
                    brk_q     <= SFBC_ENGAGE;  // RULE_17
                    brk_cnt_q <= eng_dly_q;
                end
                SFBC_ENGAGE: if (brk_cnt_q <= 32'h1) begin
                    brk_q <= SFBC_OFF;         // RULE_19
                end else begin
                    brk_cnt_q <= brk_cnt_q - 32'h1;
                end
                default: brk_q <= SFBC_OFF;
            endcase
        end
    end

    // delays and manual brake; manual command only counts when disabled
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rel_dly_q <= REL_DLY_RST;
            eng_dly_q <= ENG_DLY_RST;
            manual_q  <= 1'b0;
        end else begin
            if (wr && addr == REG_REL_DLY)
                rel_dly_q <= wdata;
            if (wr && addr == REG_ENG_DLY)
                eng_dly_q <= wdata;
            if (brk_q != SFBC_OFF)
                manual_q <= 1'b0;             // RULE_20
            else if (wr && addr == REG_BRK_CFG)
                manual_q <= wdata[0];         // RULE_20
        end
    end

    assign brake_release = (brk_q == SFBC_OFF) ? manual_q
                         : (brk_q != SFBC_ENGAGE);
    assign current_on = brk_q != SFBC_OFF;    // RULE_19
    assign motion_ok  = brk_q == SFBC_RUN;    // RULE_18

    // read port: unmapped addresses read zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            unique case (addr)
                REG_TEST_ANG: rdata <= {16'h0000, test_ang_q};
                REG_ANG_ERR:  rdata <= {16'h0000, ang_err_q}; // RULE_02
                REG_MGR_ERR:  rdata <= {16'h0000, mgr_err_q};
                REG_ABS_CFG:  rdata <= {29'h0, home_valid_q,
                                        reverse_q, abs_mode_q};
                REG_HOME_OFS: rdata <= home_ofs_q;
                REG_POS_OUT:  rdata <= pos_out_q;
                REG_PHYS_POS: rdata <= phys_pos_q;
                REG_AUX_CFG:  rdata <= {29'h0, sel_sim_q,
                                        sim_run_q, phys_dir_q};
                REG_SIM_RATE: rdata <= sim_rate_q;
                REG_SIM_POS:  rdata <= sim_pos_q;
                REG_SEL_POS:  rdata <= sel_pos_q;
                REG_SEL_RATE: rdata <= sel_rate_q;
                REG_BRK_CFG:  rdata <= {31'h0, manual_q};
                REG_REL_DLY:  rdata <= rel_dly_q;
                REG_ENG_DLY:  rdata <= eng_dly_q;
                REG_BRK_STAT: rdata <= {28'h0, brk_q};
                REG_PHYS_VEL: rdata <= phys_vel_q;
                default:      rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    a_rel_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(current_on) && rel_dly_q >= 32'h2 |-> !motion_ok [*2]) // RULE_18
        else $error("motion accepted right after enable");
    a_eng_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(motion_ok) && !motor_en_req |-> current_on && !brake_release)
        // RULE_19
        else $error("current removed before engage delay");
    a_manual_en: assert property (@(posedge mclk) disable iff (!rst_n)
        brk_q == SFBC_RUN |=> !manual_q) // RULE_20
        else $error("manual brake kept while enabled");
    a_phase_err: assert property (@(posedge mclk) disable iff (!rst_n)
        phase_busy_q && phase_done &&
        abs16(16'(meas_angle - test_ang_q)) > PHASE_ERR_LIMIT
        |=> mgr_err_q == ERR_PHASING) // RULE_03
        else $error("phasing error not reported");
    a_phase_res: assert property (@(posedge mclk) disable iff (!rst_n)
        phase_busy_q && phase_done
        |=> ang_err_q == 16'($past(meas_angle) - $past(test_ang_q))) // RULE_02
        else $error("phasing result not captured");
    a_save_cmd: assert property (@(posedge mclk) disable iff (!rst_n)
        cmd_wr && wdata[15:0] == CMD_PHASE_SAVE |=> nvm_store) // RULE_04
        else $error("save command did not store");
    a_quad_up: assert property (@(posedge mclk) disable iff (!rst_n)
        !phys_dir_q && quad_q == 2'b00 && quad_in.phase_a
        && !quad_in.phase_b |=> phys_pos_q == $past(phys_pos_q) + 32'h1)
        // RULE_15
        else $error("forward count wrong");
    a_sim_run: assert property (@(posedge mclk) disable iff (!rst_n)
        sim_run_q && !(wr && addr == REG_SIM_POS)
        |=> sim_pos_q == $past(sim_pos_q) + $past(sim_rate_q)) // RULE_13
        else $error("simulated encoder did not advance");
    a_abs_dflt: assert property (@(posedge mclk) disable iff (!rst_n)
        rst_n && !strap_done_q |=> abs_mode_q == $past(multiturn)) // RULE_06
        else $error("absolute mode default wrong");
endmodule // sfbc_top

// file: tb/sfbc_plant_model.sv
`timescale 1ns/1ps
// phasing measure unit and auxiliary quadrature encoder beside the drive
module sfbc_plant_model
    import sfbc_pkg::*;
#(
    parameter int LAT = 5                 // measure latency in cycles
)(
    input  wire logic        mclk,        // drive clock
    input  wire logic        phase_start, // pulse: begin a measure
    input  wire logic [15:0] test_ang,    // angle under test
    input  wire logic [15:0] ang_delta,   // error the bench wants measured
    output logic      [15:0] meas_angle,  // measured angle, valid with done
    output logic             phase_done,  // pulse: measure finished
    output sfbc_quad_t       quad_out     // encoder lines on I/O 0..2
);
    logic [1:0] st_q;

    initial begin
        meas_angle = 16'hA5A5;
        phase_done = 1'b0;
        quad_out   = '0;
        st_q       = 2'h0;
    end

    // answer each start; the angle bus is scrambled outside the valid cycle
    // so a design that samples late cannot read a lucky value
    always begin
        @(posedge mclk);
        if (phase_start === 1'b1) begin
            repeat (LAT) @(posedge mclk);
            meas_angle <= test_ang + ang_delta;
            phase_done <= 1'b1;
            @(posedge mclk);
            phase_done <= 1'b0;
            meas_angle <= ~(test_ang + ang_delta);
        end
    end

    // forward steps only, A leads B; index left low since it is optional
    task automatic spin(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (2) @(posedge mclk);
            st_q = st_q + 2'h1;
            quad_out.phase_a <= st_q[0] ^ st_q[1];
            quad_out.phase_b <= st_q[1];
            quad_out.index   <= 1'b0;
        end
    endtask
endmodule // sfbc_plant_model

// file: tb/tb.sv
`timescale 1ns/1ps
module tb
    import sfbc_pkg::*;
;
    logic        mclk, nrst, wr, rd, multiturn, phase_done;
    logic        phase_start, nvm_store, motor_en_req;
    logic        brake_release, current_on, motion_ok;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, sensor_pos, v, p0, p1, p2, raw, d;
    logic [15:0] meas_angle, test_ang, ang_delta;
    sfbc_quad_t  quad_in;
    int          err_total, n_tests, rdl, edl;
    logic [15:0] corner [6];

    sfbc_top u_sfbc_top (.mclk(mclk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .multiturn(multiturn), .sensor_pos(sensor_pos),
        .meas_angle(meas_angle), .phase_done(phase_done),
        .phase_start(phase_start), .nvm_store(nvm_store),
        .quad_in(quad_in), .motor_en_req(motor_en_req),
        .brake_release(brake_release), .current_on(current_on),
        .motion_ok(motion_ok));

    sfbc_plant_model #(.LAT(5)) u_sfbc_plant_model (.mclk(mclk),
        .phase_start(phase_start), .test_ang(test_ang),
        .ang_delta(ang_delta), .meas_angle(meas_angle),
        .phase_done(phase_done), .quad_out(quad_in));

    // 100 ns period
    initial mclk = 1'b0;
    always #50 mclk = ~mclk;

    task automatic stop_test();
        if (err_total == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, exp, input string m);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t %s: got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic chk1(input logic got, exp, input string m);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t %s: got %b exp %b", $time, m, got, exp);
        end
    endtask

    // error code expected for a measured minus test difference
    function automatic logic [15:0] exp_err(input logic [15:0] e);
        logic [15:0] m;
        m = e[15] ? -e : e;
        return (m > PHASE_ERR_LIMIT) ? ERR_PHASING : ERR_NONE;
    endfunction

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge mclk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= w;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    // data stand only in the cycle after the strobe, so look just past it
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] r);
        @(posedge mclk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd   <= 1'b0;
        #1 r = rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        reg_rd(a, r);
        chk32(r, e, "register read");
    endtask

    // command write, then both pulses looked at in their one cycle
    task automatic cmd_chk(input logic [15:0] c, input logic ps, nv);
        reg_wr(REG_CMD, {16'h0000, c});
        #1;
        chk1(phase_start, ps, "start pulse");
        chk1(nvm_store, nv, "store pulse");
        @(posedge mclk);
        #1;
        chk1(phase_start | nvm_store, 1'b0, "pulse width");
    endtask

    task automatic do_reset(input logic mt);
        @(posedge mclk);
        nrst      <= 1'b0;
        multiturn <= mt;
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
    endtask

    // n edges from the enable change until the sequence settles
    task automatic walk(input int n, input logic en);
        for (int k = 1; k <= n; k++) begin
            @(posedge mclk);
            #1;
            if (en)
                chk1(motion_ok, k == n, "release time");
            else
                chk1(!current_on, k == n, "engage time");
            chk1(current_on, en || k < n, "current");
            chk1(brake_release, en, "brake coil");
        end
    endtask

    initial begin
        repeat (40000) @(posedge mclk);
        err_total++;
        stop_test();
    end

    initial begin
        {nrst, wr, rd, motor_en_req} = 4'h0;
        {addr, wdata, sensor_pos} = '0;
        {test_ang, ang_delta} = '0;
        multiturn = 1'b1;
        err_total = 0;
        n_tests   = 0;
        corner = '{16'h0200, 16'h0201, 16'hFE00, 16'hFDFF, 16'h0000, 16'h8000};
        void'($urandom(32'hA535));
        do_reset(1'b1);
        // reset values and an unmapped place
        rd_chk(REG_ABS_CFG, 32'h0000_0001);
        rd_chk(REG_REL_DLY, REL_DLY_RST);
        rd_chk(REG_ENG_DLY, ENG_DLY_RST);
        rd_chk(REG_BRK_STAT, {28'h0, SFBC_OFF});
        reg_wr(8'hFC, 32'hFFFF_FFFF);
        rd_chk(8'hFC, 32'h0000_0000);
        // phasing: corner errors, then random ones
        for (int i = 0; i < 10; i++) begin
            test_ang  <= 16'($urandom);
            ang_delta <= (i < 6) ? corner[i] : 16'($urandom);
            reg_wr(REG_MGR_ERR, 32'h0000_0000);
            reg_wr(REG_TEST_ANG, {16'h0000, test_ang});
            cmd_chk(CMD_PHASE_TEST, 1'b1, 1'b0);
            repeat (10) @(posedge mclk);
            reg_rd(REG_ANG_ERR, v);
            chk32({16'h0, v[15:0]}, {16'h0, ang_delta}, "ang err");
            rd_chk(REG_MGR_ERR, {16'h0, exp_err(ang_delta)});
        end
        cmd_chk(CMD_PHASE_SAVE, 1'b0, 1'b1);
        // absolute homing, tracking past the range, reversal
        raw = $urandom & SENSOR_MAX;
        sensor_pos <= raw;
        cmd_chk(CMD_HOME, 1'b0, 1'b1);
        rd_chk(REG_HOME_OFS, -raw);
        rd_chk(REG_POS_OUT, 32'h0000_0000);
        d = SENSOR_MAX + 32'h0000_0005;
        sensor_pos <= raw + d;
        rd_chk(REG_POS_OUT, d);
        d = $urandom & SENSOR_MAX;
        sensor_pos <= raw + d;
        reg_wr(REG_ABS_CFG, 32'h0000_0003);
        rd_chk(REG_POS_OUT, SENSOR_MAX - d);
        reg_rd(REG_ABS_CFG, v);
        chk32({29'h0, v[2:0]}, 32'h0000_0007, "abs cfg");
        // auxiliary encoder, forward then reversed count direction
        reg_wr(REG_AUX_CFG, 32'h0000_0000);
        reg_rd(REG_PHYS_POS, p0);
        u_sfbc_plant_model.spin(37);
        repeat (6) @(posedge mclk);
        reg_rd(REG_PHYS_POS, p1);
        // every one of the 37 forward steps counts exactly once
        chk32(p1 - p0, 32'h0000_0025, "aux up");
        reg_wr(REG_AUX_CFG, 32'h0000_0001);
        u_sfbc_plant_model.spin(37);
        repeat (6) @(posedge mclk);
        reg_rd(REG_PHYS_POS, p2);
        chk32(p2 - p1, p0 - p1, "aux down");
        reg_wr(REG_AUX_CFG, 32'h0000_0000);
        rd_chk(REG_SEL_POS, p2);
        // simulated encoder: reads two cycles apart, then stopped
        d = $urandom & 32'h0000_0FFF;
        reg_wr(REG_SIM_RATE, d);
        reg_wr(REG_AUX_CFG, 32'h0000_0002);
        reg_rd(REG_SIM_POS, p0);
        reg_rd(REG_SIM_POS, p1);
        chk32(p1 - p0, d << 1, "sim step");
        reg_wr(REG_AUX_CFG, 32'h0000_0004);
        reg_rd(REG_SIM_POS, p0);
        reg_rd(REG_SIM_POS, p1);
        chk32(p1, p0, "sim stop");
        rd_chk(REG_SEL_POS, p1);
        rd_chk(REG_SEL_RATE, d);
        // brake: manual only while disabled, then timed sequencing
        rdl = 3 + ($urandom % 8);
        edl = 3 + ($urandom % 8);
        reg_wr(REG_REL_DLY, rdl);
        reg_wr(REG_ENG_DLY, edl);
        reg_wr(REG_BRK_CFG, 32'h0000_0001);
        rd_chk(REG_BRK_CFG, 32'h0000_0001);
        chk1(brake_release, 1'b1, "manual release");
        reg_wr(REG_BRK_CFG, 32'h0000_0000);
        @(posedge mclk);
        motor_en_req <= 1'b1;
        // the edge that takes the request, then the full delay
        walk(rdl + 1, 1'b1);
        rd_chk(REG_BRK_STAT, {28'h0, SFBC_RUN});
        reg_wr(REG_BRK_CFG, 32'h0000_0001);
        rd_chk(REG_BRK_CFG, 32'h0000_0000);
        chk1(brake_release & motion_ok, 1'b1, "manual ignored");
        @(posedge mclk);
        motor_en_req <= 1'b0;
        walk(edl + 1, 1'b0);
        rd_chk(REG_BRK_STAT, {28'h0, SFBC_OFF});
        // second reset with a singleturn sensor: incremental until set
        do_reset(1'b0);
        rd_chk(REG_ABS_CFG, 32'h0000_0000);
        reg_wr(REG_ABS_CFG, 32'h0000_0002);
        cmd_chk(CMD_HOME, 1'b0, 1'b0);
        reg_wr(REG_ABS_CFG, 32'h0000_0001);
        reg_rd(REG_ABS_CFG, v);
        chk1(v[0], 1'b1, "abs mode set");
        stop_test();
    end
endmodule // tb
